// ### hdl/hdlc_tx_defs.svh
`ifndef HDLC_TX_DEFS_SVH
`define HDLC_TX_DEFS_SVH
`define OFS_TX_CONFIG 8'h18
`define OFS_PRIORITY 8'h1C
`define OFS_SP_MOD 8'h40
`define OFS_TI_MOD 8'h44
`define OFS_TX_STATUS 8'h48
`define OFS_TX_DATA 8'h4C
`define PAGE_SP_PAT 4'h2
`define PAGE_TI_PAT 4'h3
`define RST_TX_CONFIG 8'h10
`define RST_ZERO 8'h00
`define CFG_FILL_MSB 7
`define CFG_FILL_LSB 5
`define CFG_FILL_SEL 4
`define CFG_TRANSP 3
`define CFG_ABORT 2
`define CFG_MANFCS 1
`define CFG_INIT 0
`define PRI_FORCE 0
`define DATA_LAST 8
`define SP_EXT_ZERO 2'h1
`define SP_EXT_63 2'h2
`define SP_EXT_ANY 2'h3
`define TI_EXT_OFF 2'h0
`define TI_EXT_BCAST 2'h2
`define TI_EXT_ANY 2'h3
`define SAPI_ZERO 6'h00
`define SAPI_63 6'h3F
`define TEI_BCAST 7'h7F
`define BYTE_FLAG 8'h7E
`define BYTE_ONES 8'hFF
`define BYTE_ABORT 8'h7F
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CLK_PERIOD_NS 100
`define INIT_TIME_NS 400
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_AW 6
`define FIFO_DEPTH 64
`endif

// ### hdl/hdlc_tx_pkg.sv
package hdlc_tx_pkg;
    typedef enum logic [6:0] {
        ST_INIT = 7'h01,
        ST_IDLE = 7'h02,
        ST_DATA = 7'h04,
        ST_FCS_LO = 7'h08,
        ST_FCS_HI = 7'h10,
        ST_CLOSE = 7'h20,
        ST_FILL = 7'h40
    } tx_state_t;
    typedef struct packed {
        logic [5:0] sapi;
        logic cr;
        logic [6:0] tei;
    } frame_addr_t;
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } fifo_word_t;
    typedef struct packed {
        logic [7:0] data;
        logic noStuff;
    } line_byte_t;
endpackage

// ### hdl/tx_fifo_mem.sv
`timescale 1ns/100ps
`include "hdlc_tx_defs.svh"

module tx_fifo_mem (
    input wire logic ref_clk,
    input wire logic wrEn,
    input wire logic [`FIFO_AW-1:0] wrAddr,
    input wire hdlc_tx_pkg::fifo_word_t wrData,
    input wire logic [`FIFO_AW-1:0] rdAddr,
    output hdlc_tx_pkg::fifo_word_t rdData_q
);
    hdlc_tx_pkg::fifo_word_t mem [`FIFO_DEPTH];

    // Write-first bypass, so a byte pushed into an empty FIFO is seen at once.
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_q <= (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
    end
endmodule

// ### hdl/hdlc_tx_config_addr_extend.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "hdlc_tx_defs.svh"

module hdlc_tx_config_addr_extend (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic addrValid,
    input wire hdlc_tx_pkg::frame_addr_t frameAddr,
    output logic matchValid,
    output logic passFrame,
    input wire logic byteTick,
    output hdlc_tx_pkg::line_byte_t lineByte
);
    // Reflected CRC-16 over one byte, low bit first as it goes on the line.
    function automatic logic [15:0] crcByte(input logic [15:0] crc,
                                            input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // One pattern pair with its two extend fields against a frame address.
    function automatic logic pairMatch(input hdlc_tx_pkg::frame_addr_t a,
                                       input logic [5:0] sp,
                                       input logic [6:0] ti,
                                       input logic [1:0] se,
                                       input logic [1:0] te);
        logic sapiOk;
        logic teiOk;
        sapiOk = (a.sapi == sp) || (se == `SP_EXT_ANY)
            || (se == `SP_EXT_ZERO && a.sapi == `SAPI_ZERO)
            || (se == `SP_EXT_63 && a.sapi == `SAPI_63);
        teiOk = (te != `TI_EXT_OFF) && ((a.tei == ti)
            || (te == `TI_EXT_ANY)
            || (te == `TI_EXT_BCAST && a.tei == `TEI_BCAST));
        return sapiOk && teiOk;
    endfunction

    logic ack_q;
    logic [31:0] readdata_q;
    logic [2:0] fillCount_q;
    logic fillSel_q;
    logic transp_q;
    logic manFcs_q;
    logic abort_q;
    logic init_q;
    logic force_q;
    logic [5:0] spPat_q [4];
    logic [6:0] tiPat_q [4];
    logic [7:0] spExt_q;
    logic [7:0] tiExt_q;
    logic modeTransp_q;
    logic modeMan_q;
    logic matchValid_q;
    logic passFrame_q;
    hdlc_tx_pkg::tx_state_t state_q;
    hdlc_tx_pkg::tx_state_t state_d;
    logic [2:0] initCnt_q;
    logic [2:0] gap_q;
    logic [2:0] gap_d;
    logic [15:0] crc_q;
    logic [15:0] crc_d;
    hdlc_tx_pkg::line_byte_t lineByte_q;
    hdlc_tx_pkg::line_byte_t emit;
    logic pop;
    logic [31:0] rdMux;
    logic [`FIFO_AW-1:0] wrPtr_q;
    logic [`FIFO_AW-1:0] rdPtr_q;
    logic [6:0] level_q;
    logic [6:0] frames_q;
    hdlc_tx_pkg::fifo_word_t head;

    // Bus decode. Each access is answered on the second cycle; a data write
    // into a full FIFO is held off by waitrequest until a byte leaves.
    wire busReq = read | write;
    wire selCfg = address == `OFS_TX_CONFIG;
    wire selPri = address == `OFS_PRIORITY;
    wire selSpMod = address == `OFS_SP_MOD;
    wire selTiMod = address == `OFS_TI_MOD;
    wire selData = address == `OFS_TX_DATA;
    wire selSpPat = address[7:4] == `PAGE_SP_PAT && address[1:0] == 2'h0;
    wire selTiPat = address[7:4] == `PAGE_TI_PAT && address[1:0] == 2'h0;
    wire [1:0] patIdx = address[3:2];
    wire fifoFull = level_q == 7'(`FIFO_DEPTH);
    wire stall = write & selData & fifoFull;
    wire wrDone = write & ack_q & byteenable[0];
    wire cfgWr = wrDone & selCfg;
    wire push = wrDone & selData & ~fifoFull;
    assign waitrequest = busReq & ~ack_q;
    assign readdata = readdata_q;

    // Transmit sequencing terms.
    wire tick = byteTick;
    wire inInit = state_q == hdlc_tx_pkg::ST_INIT;
    wire initDone = inInit && initCnt_q == 3'h0;
    wire startInit = init_q & ~inInit;
    wire inFrame = state_q == hdlc_tx_pkg::ST_DATA
        || state_q == hdlc_tx_pkg::ST_FCS_LO
        || state_q == hdlc_tx_pkg::ST_FCS_HI;
    wire abortTake = abort_q & (tick | inInit);
    wire flush = abortTake | inInit;
    wire flagFill = ~fillSel_q & force_q;
    wire [7:0] fillByte = flagFill ? `BYTE_FLAG : `BYTE_ONES;
    wire sharedFlag = fillCount_q == 3'h0 && force_q && frames_q != 7'h0;
    wire pushLast = push & writedata[`DATA_LAST];
    wire popLast = pop & head.last;
    wire [`FIFO_AW-1:0] rdAddr = pop ? rdPtr_q + 6'h1 : rdPtr_q;

    // Pair decode for the receive side; any of the four pairs accepts.
    wire [3:0] pairHit;
    for (genvar k = 0; k < 4; k++) begin : gPair
        assign pairHit[k] = pairMatch(frameAddr, spPat_q[k], tiPat_q[k],
            spExt_q[2*k+1:2*k], tiExt_q[2*k+1:2*k]);
    end
    assign matchValid = matchValid_q;
    assign passFrame = passFrame_q;
    assign lineByte = lineByte_q;

    tx_fifo_mem uMem (
        .ref_clk(ref_clk),
        .wrEn(push),
        .wrAddr(wrPtr_q),
        .wrData({writedata[`DATA_LAST], writedata[7:0]}),
        .rdAddr(rdAddr),
        .rdData_q(head)
    );

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rdMux = 32'h0000_0000;
        if (selCfg) begin
            rdMux[7:0] = {fillCount_q, fillSel_q, transp_q, abort_q,
                          manFcs_q, init_q};
        end else if (selPri) begin
            rdMux[`PRI_FORCE] = force_q;
        end else if (selSpMod) begin
            rdMux[7:0] = spExt_q;
        end else if (selTiMod) begin
            rdMux[7:0] = tiExt_q;
        end else if (selSpPat) begin
            rdMux[5:0] = spPat_q[patIdx];
        end else if (selTiPat) begin
            rdMux[6:0] = tiPat_q[patIdx];
        end else if (address == `OFS_TX_STATUS) begin
            rdMux[17:0] = {frames_q, level_q, fifoFull,
                           level_q == 7'h0, inFrame, inInit};
        end
    end

    // Bus handshake and read data capture in the cycle before the answer.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= busReq & ~ack_q & ~stall;
            readdata_q <= rdMux;
        end
    end

    // Configuration bits. A hardware clear never beats a software set.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {fillCount_q, fillSel_q, transp_q} <= 5'(`RST_TX_CONFIG >> 3);
            manFcs_q <= 1'b0;
            abort_q <= 1'b0;
            init_q <= 1'b0;
            force_q <= 1'b0;
        end else begin
            if (cfgWr) begin
                fillCount_q <= writedata[`CFG_FILL_MSB:`CFG_FILL_LSB];
                fillSel_q <= writedata[`CFG_FILL_SEL];
                transp_q <= writedata[`CFG_TRANSP];
                manFcs_q <= writedata[`CFG_MANFCS];
            end
            abort_q <= (cfgWr & writedata[`CFG_ABORT])
                | (abort_q & ~abortTake);
            init_q <= (cfgWr & writedata[`CFG_INIT])
                | (init_q & ~initDone);
            if (wrDone & selPri) begin
                force_q <= writedata[`PRI_FORCE];
            end
        end
    end

    // Address patterns and extend fields; all extends start at 00.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            spExt_q <= `RST_ZERO;
            tiExt_q <= `RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                spPat_q[i] <= 6'h00;
                tiPat_q[i] <= 7'h00;
            end
        end else if (wrDone) begin
            if (selSpMod) begin
                spExt_q <= writedata[7:0];
            end
            if (selTiMod) begin
                tiExt_q <= writedata[7:0];
            end
            if (selSpPat) begin
                spPat_q[patIdx] <= writedata[5:0];
            end
            if (selTiPat) begin
                tiPat_q[patIdx] <= writedata[6:0];
            end
        end
    end

    // Match result one cycle after the address is offered.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            matchValid_q <= 1'b0;
            passFrame_q <= 1'b0;
        end else begin
            matchValid_q <= addrValid;
            passFrame_q <= addrValid & (|pairHit);
        end
    end

    // FIFO pointers. A push that meets a flush is lost with the rest.
    always_ff @(posedge ref_clk) begin
        if (srst || flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= 7'h0;
            frames_q <= 7'h0;
        end else begin
            wrPtr_q <= wrPtr_q + 6'(push);
            rdPtr_q <= rdPtr_q + 6'(pop);
            level_q <= level_q + 7'(push) - 7'(pop);
            frames_q <= frames_q + 7'(pushLast) - 7'(popLast);
        end
    end

    // Transmit sequencer: one line byte decided on each byte tick.
    always_comb begin
        state_d = state_q;
        emit = '{data: fillByte, noStuff: flagFill};
        pop = 1'b0;
        crc_d = crc_q;
        gap_d = gap_q;
        case (state_q)
            hdlc_tx_pkg::ST_INIT: begin
                emit = '{data: `BYTE_ONES, noStuff: 1'b0};
                if (initDone) state_d = hdlc_tx_pkg::ST_IDLE;
            end
            hdlc_tx_pkg::ST_IDLE: begin
                if (tick && modeTransp_q) begin
                    if (level_q != 7'h0) begin
                        pop = 1'b1;
                        emit = '{data: head.data, noStuff: 1'b1};
                    end
                end else if (tick && frames_q != 7'h0) begin
                    emit = '{data: `BYTE_FLAG, noStuff: 1'b1};
                    crc_d = `CRC_INIT;
                    state_d = hdlc_tx_pkg::ST_DATA;
                end
            end
            hdlc_tx_pkg::ST_DATA: begin
                if (tick && abort_q) begin
                    emit = '{data: `BYTE_ABORT, noStuff: 1'b1};
                    state_d = hdlc_tx_pkg::ST_IDLE;
                end else if (tick) begin
                    pop = 1'b1;
                    emit = '{data: head.data, noStuff: 1'b0};
                    crc_d = crcByte(crc_q, head.data);
                    if (head.last) begin
                        state_d = modeMan_q ? hdlc_tx_pkg::ST_CLOSE
                                            : hdlc_tx_pkg::ST_FCS_LO;
                    end
                end
            end
            hdlc_tx_pkg::ST_FCS_LO, hdlc_tx_pkg::ST_FCS_HI: begin
                if (tick && abort_q) begin
                    emit = '{data: `BYTE_ABORT, noStuff: 1'b1};
                    state_d = hdlc_tx_pkg::ST_IDLE;
                end else if (tick) begin
                    emit.noStuff = 1'b0;
                    if (state_q == hdlc_tx_pkg::ST_FCS_LO) begin
                        emit.data = ~crc_q[7:0];
                        state_d = hdlc_tx_pkg::ST_FCS_HI;
                    end else begin
                        emit.data = ~crc_q[15:8];
                        state_d = hdlc_tx_pkg::ST_CLOSE;
                    end
                end
            end
            hdlc_tx_pkg::ST_CLOSE: begin
                if (tick) begin
                    emit = '{data: `BYTE_FLAG, noStuff: 1'b1};
                    if (sharedFlag) begin
                        crc_d = `CRC_INIT;
                        state_d = hdlc_tx_pkg::ST_DATA;
                    end else if (fillCount_q > 3'h1) begin
                        gap_d = fillCount_q - 3'h1;
                        state_d = hdlc_tx_pkg::ST_FILL;
                    end else begin
                        state_d = hdlc_tx_pkg::ST_IDLE;
                    end
                end
            end
            hdlc_tx_pkg::ST_FILL: begin
                if (tick) begin
                    gap_d = gap_q - 3'h1;
                    if (gap_q == 3'h1) state_d = hdlc_tx_pkg::ST_IDLE;
                end
            end
            default: state_d = hdlc_tx_pkg::ST_INIT;
        endcase
        if (startInit) state_d = hdlc_tx_pkg::ST_INIT;
    end

    // Sequencer registers; reset starts a full initialization by itself.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= hdlc_tx_pkg::ST_INIT;
            initCnt_q <= 3'(`INIT_CYCLES - 1);
            gap_q <= 3'h0;
            crc_q <= `CRC_INIT;
            lineByte_q <= '{data: `BYTE_ONES, noStuff: 1'b0};
        end else begin
            state_q <= state_d;
            gap_q <= gap_d;
            crc_q <= crc_d;
            if (tick) lineByte_q <= emit;
            if (startInit) begin
                initCnt_q <= 3'(`INIT_CYCLES - 1);
            end else if (inInit && initCnt_q != 3'h0) begin
                initCnt_q <= initCnt_q - 3'h1;
            end
        end
    end

    // Framing modes only change while initializing, so a frame never
    // switches between framed and transparent halfway through.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            modeTransp_q <= 1'b0;
            modeMan_q <= 1'b0;
        end else if (inInit) begin
            modeTransp_q <= transp_q;
            modeMan_q <= manFcs_q;
        end
    end

    // Checks on the address match and the transmit sequencer.
    AST_TEI_OFF_REJECTS: assert property (@(posedge ref_clk) disable iff (srst)
        addrValid && tiExt_q == 8'h00 |=> !passFrame)
        else $error("Frame passed with all terminal extends off.");
    AST_NO_MATCH_DROPS: assert property (@(posedge ref_clk) disable iff (srst)
        addrValid && pairHit == 4'h0 |=> matchValid && !passFrame)
        else $error("Unmatched frame was passed.");
    AST_BCAST_TEI: assert property (@(posedge ref_clk) disable iff (srst)
        addrValid && tiExt_q[1:0] == 2'h2 && frameAddr.tei == 7'h7F
        && frameAddr.sapi == spPat_q[0] |=> passFrame)
        else $error("Broadcast terminal id not accepted.");
    AST_ANY_ANY: assert property (@(posedge ref_clk) disable iff (srst)
        addrValid && spExt_q[7:6] == 2'h3 && tiExt_q[7:6] == 2'h3
        |=> passFrame)
        else $error("Open pair three did not accept the frame.");
    AST_FILL_GAP: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_CLOSE && tick && !sharedFlag
        && fillCount_q == 3'h7 && !startInit |=> gap_q == 3'h6)
        else $error("Fill count 7 did not give six fill bytes.");
    AST_SHARED_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_CLOSE && tick && sharedFlag
        && !startInit |=> state_q == hdlc_tx_pkg::ST_DATA)
        else $error("Shared flag did not open the next frame.");
    AST_NO_FORCE_NO_SHARE: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_CLOSE && !force_q
        |=> state_q != hdlc_tx_pkg::ST_DATA)
        else $error("Shared flag used without the force bit.");
    AST_FILL_ONES: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_FILL && tick && (fillSel_q || !force_q)
        |=> lineByte.data == 8'hFF)
        else $error("Fill byte not all ones.");
    AST_ABORT_SENT: assert property (@(posedge ref_clk) disable iff (srst)
        inFrame && tick && abort_q && !startInit && !cfgWr
        |=> lineByte.data == 8'h7F && !abort_q && level_q == 7'h0)
        else $error("Abort did not send abort byte and flush.");
    AST_MANUAL_FCS: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_DATA && tick && !abort_q && head.last
        && modeMan_q && !startInit |=> state_q == hdlc_tx_pkg::ST_CLOSE)
        else $error("Manual FCS mode still appended FCS.");
    AST_INIT_START: assert property (@(posedge ref_clk) disable iff (srst)
        cfgWr && writedata[0] ##1 1'b1 |=> state_q == hdlc_tx_pkg::ST_INIT)
        else $error("Initialize write did not start initialization.");
    AST_INIT_DONE: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(init_q) |-> ##[1:8] !init_q)
        else $error("Initialize bit did not return to zero.");
    AST_POWERUP_INIT: assert property (@(posedge ref_clk)
        $fell(srst) |-> inInit)
        else $error("No initialization after reset.");

    COV_SHARED: cover property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_CLOSE && tick && sharedFlag);
    COV_ABORT: cover property (@(posedge ref_clk) disable iff (srst)
        inFrame && abortTake);
    COV_PASS: cover property (@(posedge ref_clk) disable iff (srst)
        passFrame);
    COV_FILL6: cover property (@(posedge ref_clk) disable iff (srst)
        state_q == hdlc_tx_pkg::ST_FILL && gap_q == 3'h6);
endmodule

// ### bench/line_partner.sv
`timescale 1ns/100ps
// Serializer stand-in: asks for a line byte every fourth cycle while run is
// high, so the bench can stall it and queue whole frames first.
module line_partner (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic run,
    output logic byteTick
);
    logic [1:0] phase_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase_q <= 2'h0;
            byteTick <= 1'b0;
        end else begin
            phase_q <= run ? phase_q + 2'h1 : phase_q;
            byteTick <= run && (phase_q == 2'h3);
        end
    end
endmodule

// ### bench/hdlc_tx_config_addr_extend_tb.sv
`timescale 1ns/100ps
module hdlc_tx_config_addr_extend_tb;
    logic ref_clk = 0, srst = 1, read = 0, write = 0, addrValid = 0;
    logic run = 0, waitrequest, matchValid, passFrame, byteTick;
    logic [7:0] address = 8'h00, b;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rdv;
    hdlc_tx_pkg::frame_addr_t frameAddr = '0;
    hdlc_tx_pkg::line_byte_t lineByte;
    logic [7:0] seq[$];
    logic [15:0] f;
    int nErrors = 0, totalChecks = 0, k;
    int cnts[4] = '{0, 1, 3, 7};
    always #50 ref_clk = ~ref_clk;
    hdlc_tx_config_addr_extend dut (.ref_clk(ref_clk), .srst(srst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .addrValid(addrValid), .frameAddr(frameAddr),
        .matchValid(matchValid), .passFrame(passFrame),
        .byteTick(byteTick), .lineByte(lineByte));
    line_partner peer (.ref_clk(ref_clk), .srst(srst), .run(run),
        .byteTick(byteTick));
    task automatic chk(input string nm, input logic [31:0] e, g);
        totalChecks++;
        if (g !== e) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon access; the request stands until the rising edge at which
    // waitrequest is seen low, and read data are taken at that same edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400) nErrors++;
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e,
                      input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdv & m);
    endtask
    // Software polls the init bit before touching other registers.
    task automatic wait_init();
        rdv = 32'h1;
        for (int i = 0; i < 20 && rdv[0] !== 1'b0; i++) bus(0, 8'h18, 0);
        chk("init bit", 32'h0, rdv & 32'h1);
    endtask
    task automatic am(input logic [5:0] s, input logic [6:0] t,
                      input logic e);
        addrValid <= 1'b1;
        frameAddr <= '{s, 1'b0, t};
        @(posedge ref_clk);
        addrValid <= 1'b0;
        #1 chk("match valid", 32'h1, 32'(matchValid));
        chk("pass frame", 32'(e), 32'(passFrame));
        @(posedge ref_clk);
    endtask
    task automatic m(input logic [31:0] se, te);
        bus(1, 8'h40, se);
        bus(1, 8'h44, te);
    endtask
    task automatic nextb();
        @(posedge ref_clk iff byteTick === 1'b1);
        #1 b = lineByte.data;
    endtask
    // Skips idle all-ones bytes, then compares the queued expectation.
    task automatic expect_seq(input string nm);
        k = 0;
        nextb();
        while (b === 8'hFF && k < 60) begin
            nextb();
            k++;
        end
        foreach (seq[i]) begin
            if (i > 0) nextb();
            chk(nm, 32'(seq[i]), 32'(b));
        end
    endtask
    // Data byte, FCS low then high, closing flag; reflected CRC-16.
    task automatic addf(input logic [7:0] d);
        f = 16'hFFFF;
        for (int i = 0; i < 8; i++) f = (f[0] ^ d[i]) ? (f >> 1) ^ 16'h8408
                                                     : f >> 1;
        f = ~f;
        seq.push_back(d);
        seq.push_back(f[7:0]);
        seq.push_back(f[15:8]);
        seq.push_back(8'h7E);
    endtask
    // Ticks are stalled while both frames are queued.
    task automatic two_frames(input int c, input string nm);
        run <= 1'b0;
        bus(1, 8'h4C, 32'h111);
        bus(1, 8'h4C, 32'h122);
        run <= 1'b1;
        seq = '{8'h7E};
        addf(8'h11);
        repeat (c > 0 ? c - 1 : 0) seq.push_back(8'hFF);
        if (c > 0) seq.push_back(8'h7E);
        addf(8'h22);
        expect_seq(nm);
    endtask
    task automatic tally_and_finish();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        nErrors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rc(8'h18, 32'hFF, 32'h10, "config reset");
        rc(8'h50, 32'hFFFFFFFF, 32'h0, "unmapped");
        bus(1, 8'h20, 32'h05);
        bus(1, 8'h30, 32'h09);
        bus(1, 8'h28, 32'h07);
        bus(1, 8'h38, 32'h0C);
        m(32'h3, 32'h0);
        am(6'd5, 7'd9, 1'b0);
        m(32'h0, 32'h1);
        am(6'd5, 7'd9, 1'b1);
        am(6'd5, 7'd10, 1'b0);
        am(6'd4, 7'd9, 1'b0);
        m(32'h0, 32'h2);
        am(6'd5, 7'd127, 1'b1);
        am(6'd5, 7'd126, 1'b0);
        m(32'h0, 32'h3);
        am(6'd5, 7'd90, 1'b1);
        am(6'd6, 7'd90, 1'b0);
        m(32'h1, 32'h1);
        am(6'd0, 7'd9, 1'b1);
        am(6'd0, 7'd10, 1'b0);
        m(32'h2, 32'h1);
        am(6'd63, 7'd9, 1'b1);
        am(6'd62, 7'd9, 1'b0);
        m(32'h3, 32'h1);
        am(6'd40, 7'd9, 1'b1);
        am(6'd40, 7'd10, 1'b0);
        m(32'h0, 32'h10);
        am(6'd7, 7'd12, 1'b1);
        am(6'd5, 7'd9, 1'b0);
        two_frames(1, "no force");
        bus(1, 8'h1C, 32'h1);
        foreach (cnts[j]) begin
            bus(1, 8'h18, 32'({cnts[j][2:0], 5'h10}));
            two_frames(cnts[j], "fill count");
        end
        bus(1, 8'h18, 32'h0);
        repeat (2) nextb();
        chk("flag idle", 32'h7E, 32'(b));
        bus(1, 8'h1C, 32'h0);
        repeat (2) nextb();
        chk("forced ones", 32'hFF, 32'(b));
        bus(1, 8'h18, 32'h19);
        wait_init();
        bus(1, 8'h4C, 32'h13C);
        seq = '{8'h3C};
        expect_seq("raw byte");
        bus(1, 8'h18, 32'h13);
        wait_init();
        bus(1, 8'h4C, 32'h0AA);
        bus(1, 8'h4C, 32'h155);
        seq = '{8'h7E, 8'hAA, 8'h55, 8'h7E};
        expect_seq("manual fcs");
        bus(1, 8'h18, 32'h11);
        wait_init();
        run <= 1'b0;
        bus(1, 8'h4C, 32'h011);
        bus(1, 8'h4C, 32'h022);
        bus(1, 8'h4C, 32'h133);
        run <= 1'b1;
        seq = '{8'h7E};
        expect_seq("open flag");
        bus(1, 8'h18, 32'h14);
        k = 0;
        while (b !== 8'h7F && k < 8) begin
            nextb();
            k++;
        end
        chk("abort byte", 32'h7F, 32'(b));
        rc(8'h18, 32'h4, 32'h0, "abort bit");
        rc(8'h48, 32'h4, 32'h4, "fifo empty");
        tally_and_finish();
    end
endmodule
